// ---- verilog/esr_consts.vh ----
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH
// ****************************************
// Register offsets (word indices on the plain port).
// ****************************************
`define ESR_ADDR_W 4
`define ESR_OFF_EPC 4'h0
`define ESR_OFF_SR_LEG 4'h1
`define ESR_OFF_SR_EXT 4'h2
`define ESR_OFF_CAUSE_LEG 4'h3
`define ESR_OFF_CAUSE_EXT 4'h4
`define ESR_OFF_PEND 4'h5
`define ESR_OFF_CTRL 4'h6
// ****************************************
// Field positions.
// ****************************************
`define ESR_CU_HI 31
`define ESR_CU_LO 28
`define ESR_LP_BIT 27
`define ESR_FR_BIT 26
`define ESR_RE_BIT 25
`define ESR_DS_HI 24
`define ESR_DS_LO 16
`define ESR_BEV_BIT 22
`define ESR_TS_BIT 21
`define ESR_PE_BIT 20
`define ESR_CM_BIT 19
`define ESR_PZ_BIT 18
`define ESR_SWC_BIT 17
`define ESR_ISC_BIT 16
`define ESR_IM_HI 15
`define ESR_IM_LO 8
`define ESR_ERL_BIT 2
`define ESR_EXL_BIT 1
`define ESR_IE_BIT 0
// ****************************************
// Reset values.
// ****************************************
`define ESR_RST_SR_LEG 32'h00400000
`define ESR_RST_SR_EXT 32'h00000004
`define ESR_RST_EPC 32'h00000000
// ****************************************
// Cause codes.
// ****************************************
`define ESR_EXC_INT 5'h00
`define ESR_EXC_MOD 5'h01
`define ESR_EXC_TLB_REFILL_LOAD 5'h02
`define ESR_EXC_TLB_REFILL_STORE 5'h03
`define ESR_EXC_ADEL 5'h04
`define ESR_EXC_ADDR_FAULT_STORE 5'h05
`define ESR_EXC_IBE 5'h06
`define ESR_EXC_DBE 5'h07
`define ESR_EXC_SYS 5'h08
`define ESR_EXC_BP 5'h09
`define ESR_EXC_RI 5'h0A
`define ESR_EXC_CPU 5'h0B
`define ESR_EXC_OV 5'h0C
`define ESR_EXC_TR 5'h0D
`define ESR_EXC_COHERENCY_FETCH_FAULT 5'h0E
`define ESR_EXC_FPE 5'h0F
`define ESR_EXC_WATCH 5'h17
`define ESR_EXC_COHERENCY_DATA_FAULT 5'h1F
// ****************************************
// Low-power clock divider ratio.
// ****************************************
`define ESR_LP_DIV 4'h3
`endif

// ---- verilog/esr_top.v ----
// The address-and-strobe port and the register addresses were chosen for this implementation.
`include "esr_consts.vh"
module esr_top (
   // Clock and reset.
   input wire sys_clk,
   input wire rst,
   // Register port.
   input wire [`ESR_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Exception report from the pipeline.
   input wire exc_take,
   input wire [4:0] exc_code,
   input wire [31:0] exc_pc,
   input wire exc_in_delay,
   input wire [31:0] exc_branch_pc,
   input wire return_from_exception,
   // Hardware events.
   input wire [5:0] hw_irqs,
   input wire parity_err_evt,
   input wire test_miss_evt,
   input wire test_hit_evt,
   input wire tlb_shutdown_evt,
   // Decoded controls.
   output reg irq_take,
   output reg boot_vectors,
   output reg parity_clear_force,
   output reg cache_swap,
   output reg cache_isolate,
   output reg [3:0] coproc_usable,
   output reg [5:0] fp_reg_count,
   output reg byte_swap_user,
   output reg error_level,
   output reg lp_clk_en
);
   // ****************************************
   // Functions.
   // ****************************************
   // Coprocessor usable: zero is always usable in kernel mode.
   function [3:0] cu_eff;
      input [3:0] cu;
      input user;
      begin
         cu_eff = {cu[3:1], cu[0] | ~user};
      end
   endfunction
   // Legacy code keeps the low four bits only.
   function [3:0] leg_code;
      input [4:0] c;
      begin
         leg_code = c[3:0];
      end
   endfunction
   // ****************************************
   // State.
   // ****************************************
   reg [31:0] epc_reg;
   reg [31:0] sr_leg_reg;
   reg [31:0] sr_ext_reg;
   reg [4:0] code_ext_reg;
   reg [3:0] code_leg_reg;
   reg [1:0] sw_pend_reg;
   reg [5:0] hw_s1_reg;
   reg [5:0] hw_s2_reg;
   reg [3:0] div_reg;
   reg [31:0] sr_leg_next;
   reg [31:0] sr_ext_next;
   reg [4:0] code_next;
   wire wr_leg = reg_wr && (reg_addr == `ESR_OFF_SR_LEG);
   wire wr_ext = reg_wr && (reg_addr == `ESR_OFF_SR_EXT);
   wire [7:0] pend = {hw_s2_reg, sw_pend_reg};
   // Writable bit masks; unused positions hold zero in the legacy mask, and the extended mask is all ones.
   localparam [31:0] LEG_WMASK = 32'hF047FF3F;
   // Readable bit mask; the hardware-set flags at 21 to 19 are kept; 21 and 19 are not writable, and writing a one clears 20.
   localparam [31:0] LEG_RMASK = 32'hF07FFF3F;
   localparam [31:0] EXT_WMASK = 32'hFFFFFFFF;
   // ****************************************
   // Cause code filter.
   // ****************************************
   // Reserved extended codes are replaced by the reserved-instruction code.
   always @* begin
      code_next = exc_code;
      if ((exc_code > `ESR_EXC_FPE && exc_code < `ESR_EXC_WATCH) ||
          (exc_code > `ESR_EXC_WATCH && exc_code < `ESR_EXC_COHERENCY_DATA_FAULT)) begin
         code_next = `ESR_EXC_RI;
      end
   end
   // ****************************************
   // Legacy status next value.
   // ****************************************
   always @* begin
      sr_leg_next = sr_leg_reg;
      if (wr_leg) begin
         // Direct write of stack bits and controls.
         sr_leg_next = (reg_wdata & LEG_WMASK) | (sr_leg_reg & ~LEG_WMASK);
         sr_leg_next[`ESR_PE_BIT] = sr_leg_reg[`ESR_PE_BIT] & ~reg_wdata[`ESR_PE_BIT];
         sr_leg_next[`ESR_TS_BIT] = sr_leg_reg[`ESR_TS_BIT];
         sr_leg_next[`ESR_CM_BIT] = sr_leg_reg[`ESR_CM_BIT];
      end
      if (exc_take) begin
         sr_leg_next[5:2] = sr_leg_next[3:0];
         sr_leg_next[1:0] = 2'h0;
      end else if (return_from_exception) begin
         sr_leg_next[3:0] = sr_leg_next[5:2];
      end
      // Hardware sets win over a same-cycle clear.
      if (parity_err_evt) begin
         sr_leg_next[`ESR_PE_BIT] = 1'b1;
      end
      if (tlb_shutdown_evt) begin
         sr_leg_next[`ESR_TS_BIT] = 1'b1;
      end
      if (test_miss_evt && sr_leg_reg[`ESR_ISC_BIT]) begin
         sr_leg_next[`ESR_CM_BIT] = 1'b1;
      end else if (test_hit_evt && sr_leg_reg[`ESR_ISC_BIT]) begin
         sr_leg_next[`ESR_CM_BIT] = 1'b0;
      end
      sr_leg_next = sr_leg_next & LEG_RMASK;
   end
   // ****************************************
   // Extended status next value.
   // ****************************************
   always @* begin
      sr_ext_next = sr_ext_reg;
      if (wr_ext) begin
         sr_ext_next = reg_wdata & EXT_WMASK;
      end
      if (exc_take) begin
         sr_ext_next[`ESR_EXL_BIT] = 1'b1;
      end else if (return_from_exception) begin
         if (sr_ext_next[`ESR_ERL_BIT]) begin
            sr_ext_next[`ESR_ERL_BIT] = 1'b0;
         end else begin
            sr_ext_next[`ESR_EXL_BIT] = 1'b0;
         end
      end
   end
   // ****************************************
   // Registers.
   // ****************************************
   always @(posedge sys_clk) begin
      if (rst) begin
         epc_reg <= `ESR_RST_EPC;
         sr_leg_reg <= `ESR_RST_SR_LEG;
         sr_ext_reg <= `ESR_RST_SR_EXT;
         code_ext_reg <= 5'h00;
         code_leg_reg <= 4'h0;
         sw_pend_reg <= 2'h0;
         hw_s1_reg <= 6'h00;
         hw_s2_reg <= 6'h00;
      end else begin
         sr_leg_reg <= sr_leg_next;
         sr_ext_reg <= sr_ext_next;
         hw_s1_reg <= hw_irqs;
         hw_s2_reg <= hw_s1_reg;
         if (reg_wr && reg_addr == `ESR_OFF_PEND) begin
            sw_pend_reg <= reg_wdata[1:0];
         end
         if (exc_take) begin
            epc_reg <= exc_in_delay ? exc_branch_pc : exc_pc;
            code_ext_reg <= code_next;
            code_leg_reg <= leg_code(exc_code);
         end
      end
   end
   // ****************************************
   // Low-power clock enable divider.
   // ****************************************
   always @(posedge sys_clk) begin
      if (rst) begin
         div_reg <= 4'h0;
         lp_clk_en <= 1'b0;
      end else if (!sr_ext_reg[`ESR_LP_BIT]) begin
         div_reg <= 4'h0;
         lp_clk_en <= 1'b1;
      end else if (div_reg == `ESR_LP_DIV) begin
         div_reg <= 4'h0;
         lp_clk_en <= 1'b1;
      end else begin
         div_reg <= div_reg + 4'h1;
         lp_clk_en <= 1'b0;
      end
   end
   // ****************************************
   // Decoded outputs.
   // ****************************************
   always @(posedge sys_clk) begin
      if (rst) begin
         irq_take <= 1'b0;
         boot_vectors <= 1'b1;
         parity_clear_force <= 1'b0;
         cache_swap <= 1'b0;
         cache_isolate <= 1'b0;
         coproc_usable <= 4'h1;
         fp_reg_count <= 6'h10;
         byte_swap_user <= 1'b0;
         error_level <= 1'b1;
      end else begin
         irq_take <= sr_leg_reg[0] &&
                     |(pend & sr_leg_reg[`ESR_IM_HI:`ESR_IM_LO]);
         boot_vectors <= sr_leg_reg[`ESR_BEV_BIT];
         parity_clear_force <= sr_leg_reg[`ESR_PZ_BIT];
         cache_swap <= sr_leg_reg[`ESR_SWC_BIT];
         cache_isolate <= sr_leg_reg[`ESR_ISC_BIT];
         coproc_usable <= cu_eff(sr_leg_reg[`ESR_CU_HI:`ESR_CU_LO], sr_leg_reg[1]);
         fp_reg_count <= sr_ext_reg[`ESR_FR_BIT] ? 6'h20 : 6'h10;
         byte_swap_user <= sr_ext_reg[`ESR_RE_BIT] &&
                           (sr_ext_reg[4:3] == 2'h2);
         error_level <= sr_ext_reg[`ESR_ERL_BIT];
      end
   end
   // ****************************************
   // Read port; unmapped addresses read zero.
   // ****************************************
   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `ESR_OFF_EPC: reg_rdata <= epc_reg;
            `ESR_OFF_SR_LEG: reg_rdata <= sr_leg_reg;
            `ESR_OFF_SR_EXT: reg_rdata <= sr_ext_reg;
            `ESR_OFF_CAUSE_LEG: reg_rdata <= {16'h0000, pend, 2'h0, code_leg_reg, 2'h0};
            `ESR_OFF_CAUSE_EXT: reg_rdata <= {16'h0000, pend, 1'b0, code_ext_reg, 2'h0};
            `ESR_OFF_PEND: reg_rdata <= {24'h000000, pend};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule

// ---- sim/esr_checker.sv ----
`include "esr_consts.vh"
module esr_checker (
   // Clock, reset and strobes.
   input wire sys_clk, rst, reg_wr, reg_rd,
   // Register port values and reported pcs.
   input wire [`ESR_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata, reg_rdata, exc_pc, exc_branch_pc,
   // Pipeline report and decoded controls.
   input wire exc_take, exc_in_delay, return_from_exception, irq_take, boot_vectors,
   input wire parity_clear_force, cache_swap, cache_isolate, error_level, lp_clk_en,
   input wire [3:0] coproc_usable,
   input wire [5:0] fp_reg_count
);
   timeunit 1ns;
   timeprecision 100ps;
   // ******
   // Port relations.
   // ******
   // Accesses that the relations start from.
   wire quiet = !exc_take && !return_from_exception;
   wire leg_wr = reg_wr && reg_addr == `ESR_OFF_SR_LEG;
   wire ext_wr = reg_wr && reg_addr == `ESR_OFF_SR_EXT && quiet;
   wire leg_rd = reg_rd && reg_addr == `ESR_OFF_SR_LEG;
   wire pc_rd = reg_rd && reg_addr == `ESR_OFF_EPC && !exc_take;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_return_pc: assert property (
      exc_take ##2 (pc_rd && !$past(exc_take)) |=>
      reg_rdata == $past(exc_in_delay ? exc_branch_pc : exc_pc, 3)) else $error("bad return pc");
   a_boot_vec: assert property (
      leg_wr |-> ##2 boot_vectors == $past(reg_wdata[22], 2)) else $error("bad boot vector");
   a_cache_diag: assert property (
      leg_wr |-> ##2 {parity_clear_force, cache_swap, cache_isolate} == $past(reg_wdata[18:16], 2))
      else $error("bad cache control");
   a_fp_count: assert property (
      ext_wr |-> ##2 fp_reg_count == ($past(reg_wdata[26], 2) ? 6'h20 : 6'h10))
      else $error("bad fp count");
   a_error_level: assert property (
      ext_wr |-> ##2 error_level == $past(reg_wdata[2], 2)) else $error("bad error level");
   a_full_rate: assert property (
      ext_wr && !reg_wdata[27] |-> ##2 lp_clk_en [*3]) else $error("clock enable dropped");
   a_irq_masked: assert property (
      leg_wr && reg_wdata[15:8] == 8'h00 |-> ##2 !irq_take) else $error("masked irq taken");
   a_cu_kernel: assert property (
      leg_wr && quiet |-> ##2
      coproc_usable == $past({reg_wdata[31:29], reg_wdata[28] | !reg_wdata[1]}, 2))
      else $error("bad coprocessor usable");
   a_unused_zero: assert property (
      leg_rd |=> (reg_rdata & 32'h0F8000C0) == 32'h0) else $error("unused bits set");
   c_delay_slot: cover property (exc_take && exc_in_delay);
   c_pop: cover property (return_from_exception);
   c_irq: cover property (irq_take);
endmodule

// ---- sim/esr_pipe_model.sv ----
module esr_pipe_model (
   // Clock.
   input wire sys_clk,
   // Exception report and return.
   output logic exc_take, exc_in_delay, return_from_exception,
   output logic [4:0] exc_code,
   output logic [31:0] exc_pc, exc_branch_pc
);
   timeunit 1ns;
   timeprecision 100ps;
   // Nothing is reported at time zero.
   initial {exc_take, exc_in_delay, return_from_exception, exc_code, exc_pc, exc_branch_pc} = '0;
   // One-cycle report; released pc lines show inverted data, never a stale match.
   task automatic raise(input logic [4:0] c, input logic [31:0] pc, input logic dly);
      @(posedge sys_clk);
      {exc_take, exc_code, exc_in_delay} <= {1'b1, c, dly};
      {exc_pc, exc_branch_pc} <= {pc, pc - 32'h4};
      @(posedge sys_clk);
      {exc_take, exc_in_delay} <= {1'b0, ~dly};
      {exc_pc, exc_branch_pc} <= ~{pc, pc - 32'h4};
   endtask
   // One-cycle return from an exception handler.
   task automatic ret();
      @(posedge sys_clk);
      return_from_exception <= 1'b1;
      @(posedge sys_clk);
      return_from_exception <= 1'b0;
   endtask
endmodule

// ---- sim/test_exception_status_regs.sv ----
`include "esr_consts.vh"
module test_exception_status_regs;
   timeunit 1ns;
   timeprecision 100ps;
   // ******
   // Stimulus and tallies.
   // ******
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [`ESR_ADDR_W-1:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [5:0] hw_irqs = 6'h00;
   logic [3:0] ev = 4'h0;
   logic [4:0] c;
   logic [31:0] pc;
   int bad_count = 0;
   int checks_done = 0;
   wire [31:0] reg_rdata, exc_pc, exc_branch_pc;
   wire [4:0] exc_code;
   wire [3:0] coproc_usable;
   wire [5:0] fp_reg_count;
   wire exc_take, exc_in_delay, return_from_exception, irq_take, boot_vectors;
   wire parity_clear_force, cache_swap, cache_isolate, byte_swap_user, error_level, lp_clk_en;
   wire parity_err_evt = ev[0];
   wire tlb_shutdown_evt = ev[1];
   wire test_miss_evt = ev[2];
   wire test_hit_evt = ev[3];
   esr_top esr_top_i (.*);
   esr_pipe_model esr_pipe_model_i (.*);
   // Free-running clock.
   initial forever #12.5 sys_clk = ~sys_clk;
   // Compare, count and report.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, e);
   endtask
   task automatic lp_count(input logic [31:0] e);
      logic [31:0] k;
      k = 32'h0;
      repeat (8) begin
         @(negedge sys_clk);
         k = k + {31'h0, lp_clk_en};
      end
      chk(k, e);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(`ESR_OFF_SR_LEG, 32'h00400000);
      rdc(`ESR_OFF_SR_EXT, 32'h00000004);
      wr(`ESR_OFF_EPC, 32'hFFFFFFFF);
      rdc(`ESR_OFF_EPC, 32'h0);
      $display("reset done");
      for (int i = 0; i < 19; i++) begin
         c = (i < 16) ? i[4:0] : ((i == 16) ? 5'h17 : ((i == 17) ? 5'h1F : 5'h14));
         pc = 32'h1000 + 32'(i * 8);
         esr_pipe_model_i.raise(c, pc, i[0]);
         rdc(`ESR_OFF_EPC, i[0] ? pc - 32'h4 : pc);
         rdc(`ESR_OFF_CAUSE_EXT, {25'h0, (i == 18) ? 5'h0A : c, 2'h0});
         rdc(`ESR_OFF_CAUSE_LEG, {26'h0, c[3:0], 2'h0});
      end
      $display("codes done");
      wr(`ESR_OFF_SR_LEG, 32'hEFFFFF0B);
      rdc(`ESR_OFF_SR_LEG, 32'hE047FF0B);
      wr(`ESR_OFF_PEND, 32'hFD);
      rdc(`ESR_OFF_CAUSE_LEG, 32'h110);
      chk({31'h0, irq_take}, 32'h1);
      wr(`ESR_OFF_PEND, 32'h0);
      @(posedge sys_clk) hw_irqs <= 6'h20;
      // Let the source pass both synchroniser stages before reading it back.
      @(posedge sys_clk);
      rdc(`ESR_OFF_CAUSE_LEG, 32'h8010);
      @(posedge sys_clk) hw_irqs <= 6'h00;
      esr_pipe_model_i.raise(5'h00, 32'h2000, 1'b0);
      rdc(`ESR_OFF_SR_LEG, 32'hE047FF2C);
      chk({28'h0, coproc_usable}, 32'hF);
      esr_pipe_model_i.ret();
      rdc(`ESR_OFF_SR_LEG, 32'hE047FF2B);
      $display("stack done");
      @(posedge sys_clk) ev <= 4'h7;
      @(posedge sys_clk) ev <= 4'h0;
      rdc(`ESR_OFF_SR_LEG, 32'hE07FFF2B);
      wr(`ESR_OFF_SR_LEG, 32'hE057FF2B);
      rdc(`ESR_OFF_SR_LEG, 32'hE06FFF2B);
      @(posedge sys_clk) ev <= 4'h8;
      @(posedge sys_clk) ev <= 4'h0;
      rdc(`ESR_OFF_SR_LEG, 32'hE067FF2B);
      wr(`ESR_OFF_SR_LEG, 32'h0);
      $display("diag done");
      wr(`ESR_OFF_SR_EXT, 32'h0E000010);
      rdc(`ESR_OFF_SR_EXT, 32'h0E000010);
      chk({31'h0, byte_swap_user}, 32'h1);
      lp_count(32'h2);
      wr(`ESR_OFF_SR_EXT, 32'h0);
      rdc(`ESR_OFF_SR_EXT, 32'h0);
      lp_count(32'h8);
      $display("extended done");
      tally_and_finish();
   end
endmodule
bind esr_top esr_checker esr_checker_i (.*);
